// ### ipf_defines.vh
// constants for the input port function logic
// assumes inclusion by both design files; definitions only
`ifndef IPF_DEFINES_VH
`define IPF_DEFINES_VH
// function codes, 3 bits per port
`define IPF_FN_W 3
`define IPF_FN_NONE 3'h0
`define IPF_FN_LIMP 3'h1
`define IPF_FN_LIMN 3'h2
`define IPF_FN_HOME 3'h3
`define IPF_FN_JOGP 3'h4
`define IPF_FN_JOGN 3'h5
`define IPF_FN_GO 3'h6
`define IPF_FN_STOP 3'h7
// register offsets on the plain register port
`define IPF_ADDR_W 4
`define IPF_REG_RAW 4'h0
`define IPF_REG_FUNC 4'h1
`define IPF_REG_STAT 4'h2
`define IPF_REG_SAVE 4'h3
`define IPF_REG_FUNC_HI 4'h4
// status field positions
`define IPF_ST_PROG 0
`define IPF_ST_JOGP 1
`define IPF_ST_JOGN 2
`define IPF_ST_LIMP 3
`define IPF_ST_LIMN 4
`define IPF_ST_HOME 5
`define IPF_ST_STOP 6
`endif

// ### ipf_sync.v
// two-flop synchroniser for a vector of pins, inverted to active high
// assumes pins are asynchronous to clock; pin low means active
`include "ipf_defines.vh"
module ipf_sync #(
    parameter WIDTH = 12
) (
    input wire clock,
    input wire rst_b,
    input wire [WIDTH-1:0] pin_in_b,
    output reg [WIDTH-1:0] active_r
);
    reg [WIDTH-1:0] meta_r;

    // first stage read only by the second; reset to inactive (pins idle high)
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta_r <= {WIDTH{1'b0}};
            active_r <= {WIDTH{1'b0}};
        end
        else
        begin
            meta_r <= ~pin_in_b;
            active_r <= meta_r;
        end
    end
endmodule // ipf_sync

// ### ipf_top.v
// input port function logic: raw data, fixed-function decode, motion requests
// assumes the motion engine and program sequencer sit outside; pins are active low
//
// Chosen here: the placing of the registers and strobed register access.
`include "ipf_defines.vh"
module ipf_top #(
    parameter NPORT = 12
) (
    input wire clock,
    input wire rst_b,
    input wire [NPORT-1:0] pin_in_b,
    input wire [`IPF_ADDR_W-1:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    input wire [NPORT*`IPF_FN_W-1:0] nv_func,
    output reg nv_load_req_r,
    input wire nv_load_done,
    output reg nv_save_r,
    output reg [NPORT*`IPF_FN_W-1:0] nv_save_data_r,
    input wire prog_running,
    input wire prog_done,
    output reg prog_start_r,
    output reg [7:0] prog_start_addr_r,
    output reg prog_abort_r,
    output reg stop_decel_r,
    output reg motion_cancel_r,
    output reg jog_pos_r,
    output reg jog_neg_r,
    input wire req_pos,
    input wire req_neg,
    output reg allow_pos_r,
    output reg allow_neg_r,
    output reg home_switch_r,
    output reg [NPORT-1:0] raw_data_r,
    output reg [NPORT-1:0] branch_data_r
);
    localparam [7:0] PROG_ORIGIN = 8'h00;
    localparam ST_LOAD = 1'b0;
    localparam ST_RUN = 1'b1;
    // function image is wider than the bus: upper ports live in a second word
    localparam FW = NPORT*`IPF_FN_W;

    wire [NPORT-1:0] act;
    reg [NPORT*`IPF_FN_W-1:0] func_r;
    reg state_r;
    reg go_prev_r;
    reg [NPORT-1:0] m_limp, m_limn, m_home, m_jogp, m_jogn, m_go, m_stop;
    reg any_limp, any_limn, any_home, any_jogp, any_jogn, any_go, any_stop;
    reg [NPORT-1:0] nobranch;
    integer i;

    // return the function code of one port
    function [`IPF_FN_W-1:0] fn_of;
        input [NPORT*`IPF_FN_W-1:0] all;
        input integer idx;
        begin
            fn_of = all[idx*`IPF_FN_W +: `IPF_FN_W];
        end
    endfunction

    ipf_sync #(
        .WIDTH(NPORT)
    ) u_sync (
        .clock(clock),
        .rst_b(rst_b),
        .pin_in_b(pin_in_b),
        .active_r(act)
    );

    // decode which active ports carry which function
    always @*
    begin
        m_limp = {NPORT{1'b0}};
        m_limn = {NPORT{1'b0}};
        m_home = {NPORT{1'b0}};
        m_jogp = {NPORT{1'b0}};
        m_jogn = {NPORT{1'b0}};
        m_go = {NPORT{1'b0}};
        m_stop = {NPORT{1'b0}};
        nobranch = {NPORT{1'b0}};
        for (i = 0; i < NPORT; i = i + 1)
        begin
            case (fn_of(func_r, i))
                `IPF_FN_LIMP: m_limp[i] = act[i];
                `IPF_FN_LIMN: m_limn[i] = act[i];
                `IPF_FN_HOME: m_home[i] = act[i];
                `IPF_FN_JOGP: m_jogp[i] = act[i];
                `IPF_FN_JOGN: m_jogn[i] = act[i];
                `IPF_FN_GO: m_go[i] = act[i];
                `IPF_FN_STOP: m_stop[i] = act[i];
                default: m_go[i] = 1'b0;
            endcase
            if (fn_of(func_r, i) == `IPF_FN_STOP || fn_of(func_r, i) == `IPF_FN_JOGP ||
                fn_of(func_r, i) == `IPF_FN_JOGN)
                nobranch[i] = 1'b1;
        end
        any_limp = |m_limp;
        any_limn = |m_limn;
        any_home = |m_home;
        any_jogp = |m_jogp;
        any_jogn = |m_jogn;
        any_go = |m_go;
        any_stop = |m_stop;
    end

    // configuration: default then reload from non-volatile store after reset
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r <= ST_LOAD;
            func_r <= {NPORT*`IPF_FN_W{1'b0}};
            nv_load_req_r <= 1'b1;
            nv_save_r <= 1'b0;
            nv_save_data_r <= {NPORT*`IPF_FN_W{1'b0}};
        end
        else
        begin
            nv_save_r <= 1'b0;
            case (state_r)
                ST_LOAD:
                begin
                    // writes are ignored until the stored image is in place
                    if (nv_load_done)
                    begin
                        func_r <= nv_func;
                        nv_load_req_r <= 1'b0;
                        state_r <= ST_RUN;
                    end
                end
                ST_RUN:
                begin
                    if (reg_wr && reg_addr == `IPF_REG_FUNC)
                        func_r[31:0] <= reg_wdata;
                    if (reg_wr && reg_addr == `IPF_REG_FUNC_HI)
                        func_r[FW-1:32] <= reg_wdata[FW-33:0];
                    if (reg_wr && reg_addr == `IPF_REG_SAVE && reg_wdata[0])
                    begin
                        nv_save_r <= 1'b1;
                        nv_save_data_r <= func_r;
                    end
                end
                default: state_r <= ST_LOAD;
            endcase
        end
    end

    // motion and program requests derived from the active functions
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            go_prev_r <= 1'b0;
            prog_start_r <= 1'b0;
            prog_start_addr_r <= PROG_ORIGIN;
            prog_abort_r <= 1'b0;
            stop_decel_r <= 1'b0;
            motion_cancel_r <= 1'b0;
            jog_pos_r <= 1'b0;
            jog_neg_r <= 1'b0;
            allow_pos_r <= 1'b0;
            allow_neg_r <= 1'b0;
            home_switch_r <= 1'b0;
            raw_data_r <= {NPORT{1'b0}};
            branch_data_r <= {NPORT{1'b0}};
        end
        else
        begin
            go_prev_r <= any_go;
            // edge start, or restart on completion while held; stop and jog win
            prog_start_r <= !any_stop && !any_jogp && !any_jogn &&
                ((any_go && !go_prev_r && !prog_running) ||
                 (any_go && prog_done));
            prog_start_addr_r <= PROG_ORIGIN;
            prog_abort_r <= any_stop || any_jogp || any_jogn;
            stop_decel_r <= any_stop;
            motion_cancel_r <= any_jogp || any_jogn;
            // stop overrides jog; opposing jogs cancel each other
            jog_pos_r <= any_jogp && !any_jogn && !any_stop && !any_limp;
            jog_neg_r <= any_jogn && !any_jogp && !any_stop && !any_limn;
            allow_pos_r <= req_pos && !any_limp && !any_stop;
            allow_neg_r <= req_neg && !any_limn && !any_stop;
            home_switch_r <= any_home;
            raw_data_r <= act;
            branch_data_r <= act & ~nobranch;
        end
    end

    // register read: data one cycle after the strobe, zero otherwise
    always @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            reg_rdata <= 32'h00000000;
        else if (reg_rd)
        begin
            case (reg_addr)
                `IPF_REG_RAW: reg_rdata <= {{(32-NPORT){1'b0}}, act};
                `IPF_REG_FUNC: reg_rdata <= func_r[31:0];
                `IPF_REG_FUNC_HI: reg_rdata <= {{(64-FW){1'b0}}, func_r[FW-1:32]};
                `IPF_REG_STAT:
                begin
                    reg_rdata <= 32'h00000000;
                    reg_rdata[`IPF_ST_PROG] <= prog_running;
                    reg_rdata[`IPF_ST_JOGP] <= any_jogp;
                    reg_rdata[`IPF_ST_JOGN] <= any_jogn;
                    reg_rdata[`IPF_ST_LIMP] <= any_limp;
                    reg_rdata[`IPF_ST_LIMN] <= any_limn;
                    reg_rdata[`IPF_ST_HOME] <= any_home;
                    reg_rdata[`IPF_ST_STOP] <= any_stop;
                end
                default: reg_rdata <= 32'h00000000;
            endcase
        end
        else
            reg_rdata <= 32'h00000000;
    end
endmodule // ipf_top

// ### ipf_chk_asserts.sv
// port-level timing checks for ipf_top
// assumes binding into ipf_top; sees its ports only
`include "ipf_defines.vh"
module ipf_chk #(parameter NPORT = 12) (
    input wire clock,
    input wire rst_b,
    input wire [NPORT-1:0] pin_in_b,
    input wire [`IPF_ADDR_W-1:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    input wire nv_load_req_r,
    input wire nv_save_r,
    input wire prog_running,
    input wire prog_done,
    input wire prog_start_r,
    input wire [7:0] prog_start_addr_r,
    input wire stop_decel_r,
    input wire motion_cancel_r,
    input wire jog_pos_r,
    input wire jog_neg_r,
    input wire req_pos,
    input wire req_neg,
    input wire allow_pos_r,
    input wire allow_neg_r,
    input wire [NPORT-1:0] raw_data_r
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    // a save is only honoured once loading has finished
    sequence save_wr;
        reg_wr && reg_addr == `IPF_REG_SAVE && reg_wdata[0] && !nv_load_req_r;
    endsequence
    sequence save_pulse;
        nv_save_r ##1 !nv_save_r;
    endsequence
    save_pulse_a: assert property (save_wr |=> save_pulse)
        else $error("save pulse missing");
    raw_follow_a: assert property (raw_data_r == ~$past(pin_in_b, 3))
        else $error("raw data wrong");
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
        else $error("read data not idle");
    start_cause_a: assert property (prog_start_r |-> (!$past(prog_running) || $past(prog_done))
        && prog_start_addr_r == 8'h00)
        else $error("start without cause");
    start_once_a: assert property (prog_start_r |=> !prog_start_r)
        else $error("start pulse too long");
    allow_pos_a: assert property (allow_pos_r |-> $past(req_pos))
        else $error("positive grant without request");
    allow_neg_a: assert property (allow_neg_r |-> $past(req_neg))
        else $error("negative grant without request");
    stop_all_a: assert property (stop_decel_r |-> !allow_pos_r && !allow_neg_r
        && !jog_pos_r && !jog_neg_r)
        else $error("motion during stop");
    jog_cancel_a: assert property ((jog_pos_r || jog_neg_r) |-> motion_cancel_r
        && !(jog_pos_r && jog_neg_r))
        else $error("jog without cancel");
endmodule // ipf_chk
bind ipf_top ipf_chk #(.NPORT(NPORT)) u_chk (.clock, .rst_b, .pin_in_b, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .nv_load_req_r, .nv_save_r, .prog_running, .prog_done,
    .prog_start_r, .prog_start_addr_r, .stop_decel_r, .motion_cancel_r, .jog_pos_r,
    .jog_neg_r, .req_pos, .req_neg, .allow_pos_r, .allow_neg_r, .raw_data_r);

// ### ipf_sw.sv
// switch bank driving the active-low input pins
// assumes pull-ups on every pin: an open contact reads high
module ipf_sw #(parameter NPORT = 12) (
    input wire [NPORT-1:0] closed,
    output wire [NPORT-1:0] pin_in_b
);
    timeunit 1ns;
    timeprecision 1ns;
    // closed contact grounds the pin, an open one floats up to the pull-up
    assign pin_in_b = ~closed;
endmodule // ipf_sw

// ### ipf_top_tb.sv
// self-checking bench for ipf_top
// assumes ipf_sw as the switch bank and ipf_chk bound into the design
`include "ipf_defines.vh"
module ipf_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, nv_load_done = 1'b0;
    logic prog_running = 1'b0, prog_done = 1'b0, req_pos = 1'b1, req_neg = 1'b1;
    logic [11:0] closed = 12'h000;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000, rd_val;
    logic [35:0] nv_func = 36'h0_0000_0600; // port 3 stored as home
    wire [11:0] pin_in_b, raw_data_r, branch_data_r;
    wire [31:0] reg_rdata;
    wire [35:0] nv_save_data_r;
    wire [7:0] prog_start_addr_r;
    wire nv_load_req_r, nv_save_r, prog_start_r, prog_abort_r, stop_decel_r, motion_cancel_r;
    wire jog_pos_r, jog_neg_r, allow_pos_r, allow_neg_r, home_switch_r;
    int mismatches = 0, check_count = 0, starts;
    ipf_sw u_sw (.closed, .pin_in_b);
    ipf_top u_dut (.clock, .rst_b, .pin_in_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .nv_func, .nv_load_req_r, .nv_load_done, .nv_save_r, .nv_save_data_r,
        .prog_running, .prog_done, .prog_start_r, .prog_start_addr_r, .prog_abort_r,
        .stop_decel_r, .motion_cancel_r, .jog_pos_r, .jog_neg_r, .req_pos, .req_neg,
        .allow_pos_r, .allow_neg_r, .home_switch_r, .raw_data_r, .branch_data_r);
    // 20 MHz clock
    initial
    begin
        forever #25 clock = ~clock;
    end
    task automatic check(input logic [35:0] got, input logic [35:0] exp);
        check_count++;
        if (got !== exp)
            begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 rd_val = reg_rdata;
    endtask
    // start is a one-cycle pulse, so sample every cycle
    task automatic count(input int n);
        starts = 0;
        repeat (n)
        begin
            #1 starts += int'(prog_start_r === 1'b1);
            @(posedge clock);
        end
    endtask
    task automatic do_reset;
        closed <= 12'h000;
        rst_b <= 1'b0;
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        rd(`IPF_REG_FUNC);
        check(rd_val, 36'h0);
        check(nv_load_req_r, 36'h1);
        nv_load_done <= 1'b1;
        @(posedge clock);
        nv_load_done <= 1'b0;
        rd(`IPF_REG_FUNC);
        check(rd_val, nv_func[31:0]);
        rd(`IPF_REG_FUNC_HI);
        check(rd_val, nv_func[35:32]);
        check(nv_load_req_r, 36'h0);
    endtask
    task automatic t_raw;
        closed <= 12'hA53;
        rd(`IPF_REG_RAW);
        repeat (4) @(posedge clock);
        rd(`IPF_REG_RAW);
        check(rd_val, 36'hA53);
        check(branch_data_r, 36'hA53);
        check(home_switch_r, 36'h0);
        closed <= 12'h008;
        repeat (4) @(posedge clock);
        check(home_switch_r, 36'h1);
        check(raw_data_r, 36'h008);
        closed <= 12'h000;
    endtask
    // every code on port 0, pressed then released, with both directions requested
    task automatic t_codes;
        logic [6:0] stat_tab [8] = '{7'h00, 7'h08, 7'h10, 7'h20, 7'h02, 7'h04, 7'h00, 7'h40};
        for (int c = 0; c < 8; c++)
        begin
            wr(`IPF_REG_FUNC, 32'(c));
            closed <= 12'h001;
            count(6);
            check(starts, 36'(c == 6));
            rd(`IPF_REG_STAT);
            check(rd_val, 36'(stat_tab[c]));
            check(raw_data_r[0], 36'h1);
            check(branch_data_r[0], 36'(c != 4 && c != 5 && c != 7));
            check(allow_pos_r, 36'(c != 1 && c != 7));
            check(allow_neg_r, 36'(c != 2 && c != 7));
            check(stop_decel_r, 36'(c == 7));
            check(jog_pos_r, 36'(c == 4));
            check(jog_neg_r, 36'(c == 5));
            check(motion_cancel_r, 36'(c == 4 || c == 5));
            check(prog_abort_r, 36'(c == 4 || c == 5 || c == 7));
            closed <= 12'h000;
            repeat (4) @(posedge clock);
            check({jog_pos_r, jog_neg_r}, 36'h0);
        end
    endtask
    task automatic t_go;
        wr(`IPF_REG_FUNC, 32'h0000_0006);
        prog_running <= 1'b1;
        closed <= 12'h001;
        count(6);
        check(starts, 36'h0);
        prog_done <= 1'b1;
        prog_running <= 1'b0;
        @(posedge clock);
        prog_done <= 1'b0;
        prog_running <= 1'b1;
        count(4);
        check(starts, 36'h1);
        check(prog_start_addr_r, 36'h0);
        closed <= 12'h000;
        prog_running <= 1'b0;
        wr(`IPF_REG_SAVE, 32'h0000_0001);
        #1 check(nv_save_r, 36'h1);
        check(nv_save_data_r, 36'h6);
        rd(4'hF);
        check(rd_val, 36'h0);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // main sequence, ending with a second reset to prove the reload
    initial
    begin
        do_reset;
        t_raw;
        t_codes;
        t_go;
        do_reset;
        test_done;
    end
    // the whole run needs well under 2000 cycles
    initial
    begin
        repeat (20000) @(posedge clock);
        mismatches++;
        test_done;
    end
endmodule // ipf_top_tb
